// >>> rtl/dmc_channel_copy.sv
// Four-channel byte DMA engine: fly-by device transfers and ch0->ch1 memory copy.
// Assumes a synchronous 8-bit register master and memory that returns read
// data in the cycle after mem_rd_o.
// Operation
// - ISA memory device transfers only on channels 2,3
// - Memory copy uses channels 0,1 in block mode
// - Copy needs memory copy enable bit set
// - Channel 0 source address, channel 1 destination
// - Channel 1 count sets length, channel 1 ends
// - Copy starts only by software request channel 0
// - Registers except window and interrupt ones reachable only with window select value
// - Byte pointer toggle selects low then high byte
// - Status read clears terminal count flags
`timescale 1ns/1ps
`default_nettype none

module dmc_channel_copy #(
    parameter logic [7:0] WINDOW_SEL = 8'h40 // dmac_window_select_value
) (
    input wire logic ref_clk_i, // 40 MHz clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic [4:0] reg_addr_i, // Register address
    input wire logic [7:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
    input wire logic [3:0] drq_i, // Peripheral requests
    output logic [3:0] dack_o, // Peripheral acknowledges
    output logic [15:0] mem_addr_o, // Memory address
    output logic mem_rd_o, // Memory read strobe
    output logic mem_wr_o, // Memory write strobe
    output logic [7:0] mem_wdata_o, // Memory write data (copy)
    input wire logic [7:0] mem_rdata_i, // Memory read data
    output logic tc_o, // Terminal count pulse
    output logic irq_o // Interrupt, level
);
    typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_CP_RD, ST_CP_WAIT, ST_CP_WR} dmc_state_type;

    // Address match used by both write and read decodes
    function automatic logic dmc_hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction

    // Lowest numbered active request wins
    function automatic logic [1:0] dmc_first(input logic [3:0] r);
        logic [1:0] c;
        c = 2'h3;
        if (r[2]) c = 2'h2;
        if (r[1]) c = 2'h1;
        if (r[0]) c = 2'h0;
        return c;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    dmc_state_type state_reg, state_next;
    logic [1:0] ch_reg, ch_next;
    logic [7:0] window_reg;
    logic [7:0] cmd_reg;
    logic [7:0] mode_reg [4];
    logic [15:0] addr_reg [4];
    logic [15:0] cnt_reg [4];
    logic [3:0] mask_reg, sreq_reg, tc_reg, ist_reg, imask_reg;
    logic ptr_reg;
    logic [7:0] rdata_reg;
    logic [3:0] dack_reg, dack_next;
    logic [15:0] maddr_reg, maddr_next;
    logic mrd_reg, mrd_next, mwr_reg, mwr_next;
    logic [7:0] mwd_reg, mwd_next;
    logic tco_reg, irq_reg;
    logic [3:0] step_ch, tc_hit;
    logic copy_end;

    // ************************************************************
    // Register decode
    // ************************************************************
    // Window and interrupt registers stay reachable while the window is closed
    wire win_open = window_reg == WINDOW_SEL;
    wire wr_dma = reg_wr_i && win_open;
    wire rd_dma = reg_rd_i && win_open;
    wire chan_sel = reg_addr_i < dmc_pkg::OFF_CMD;
    wire [1:0] acc_ch = reg_addr_i[2:1];
    wire acc_cnt = reg_addr_i[0];
    wire wr_chan = wr_dma && chan_sel;
    wire rd_chan = rd_dma && chan_sel;
    wire wr_cmd = wr_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_CMD);
    wire wr_req = wr_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_REQ);
    wire wr_mask = wr_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_MASK);
    wire wr_mode = wr_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_MODE);
    wire wr_clr = wr_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_CLR_PTR);
    wire rd_stat = rd_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_STATUS);
    wire wr_win = reg_wr_i && dmc_hit(reg_addr_i, dmc_pkg::OFF_WINDOW);
    wire wr_ist = reg_wr_i && dmc_hit(reg_addr_i, dmc_pkg::OFF_IRQ_STAT);
    wire wr_imask = reg_wr_i && dmc_hit(reg_addr_i, dmc_pkg::OFF_IRQ_MASK);
    wire [1:0] sel_ch = reg_wdata_i[dmc_pkg::SEL_CH_LSB +: 2];
    wire sel_set = reg_wdata_i[dmc_pkg::SEL_SET_BIT];

    // Toggle flips on each byte access, cleared by its own write
    wire ptr_next = wr_clr ? 1'b0 : ((wr_chan || rd_chan) ? ~ptr_reg : ptr_reg);

    // ************************************************************
    // Per-channel registers
    // ************************************************************
    wire copy_on = cmd_reg[dmc_pkg::CMD_COPY_BIT];
    logic [3:0] mask_next, sreq_next, dev_req;
    logic [3:0] blk_mode, dir_wr;
    logic [15:0] addr_cur, cnt_cur;

    for (genvar g = 0; g < 4; g++) begin : g_ch
        wire here = acc_ch == 2'(g);
        wire sel_here = sel_ch == 2'(g);
        wire wr_a = wr_chan && here && !acc_cnt;
        wire wr_c = wr_chan && here && acc_cnt;
        wire [1:0] mode_sel = mode_reg[g][dmc_pkg::MODE_SEL_LSB +: 2];
        // Channels 0/1 may not aim device transfers at the ISA half
        wire isa_ok = (g >= 2) || addr_reg[g][dmc_pkg::ADDR_HI_BIT];
        wire in_copy = copy_on && dmc_pkg::COPY_PAIR[g];
        assign blk_mode[g] = mode_sel == dmc_pkg::MODE_BLOCK;
        assign dir_wr[g] = mode_reg[g][dmc_pkg::MODE_DIR_BIT];
        assign dev_req[g] = (drq_i[g] || sreq_reg[g]) && !mask_reg[g] && isa_ok && !in_copy;
        // A finished channel masks itself until software reopens it
        assign mask_next[g] = (wr_mask && sel_here) ? sel_set : (tc_hit[g] | mask_reg[g]);
        assign sreq_next[g] = (wr_req && sel_here) ? sel_set :
            (sreq_reg[g] && !tc_hit[g] && !(copy_end && g == 0));

        // Address and count: byte writes via the toggle, or engine steps
        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                addr_reg[g] <= dmc_pkg::WORD_RST;
                cnt_reg[g] <= dmc_pkg::WORD_RST;
                mode_reg[g] <= dmc_pkg::MODE_RST;
            end else begin
                if (wr_a && ptr_reg) begin
                    addr_reg[g][15:8] <= reg_wdata_i;
                end else if (wr_a) begin
                    addr_reg[g][7:0] <= reg_wdata_i;
                end else if (step_ch[g]) begin
                    addr_reg[g] <= addr_reg[g] + dmc_pkg::WORD_STEP;
                end
                if (wr_c && ptr_reg) begin
                    cnt_reg[g][15:8] <= reg_wdata_i;
                end else if (wr_c) begin
                    cnt_reg[g][7:0] <= reg_wdata_i;
                end else if (step_ch[g]) begin
                    cnt_reg[g] <= cnt_reg[g] - dmc_pkg::WORD_STEP;
                end
                if (wr_mode && sel_here) begin
                    mode_reg[g] <= reg_wdata_i;
                end
            end
        end
    end

    assign addr_cur = addr_reg[ch_reg];
    assign cnt_cur = cnt_reg[ch_reg];
    wire cur_last = cnt_cur == dmc_pkg::CNT_LAST;
    wire dst_last = cnt_reg[dmc_pkg::CH_DST] == dmc_pkg::CNT_LAST;
    wire [1:0] pick = dmc_first(dev_req);

    // Copy runs only on a software request with both channels in block mode
    wire copy_go = copy_on && sreq_reg[dmc_pkg::CH_SRC] &&
        blk_mode[dmc_pkg::CH_SRC] && blk_mode[dmc_pkg::CH_DST];

    // Device burst continues in block mode, or demand mode while requested
    wire [1:0] cur_mode = mode_reg[ch_reg][dmc_pkg::MODE_SEL_LSB +: 2];
    wire keep_on = blk_mode[ch_reg] ||
        (cur_mode == dmc_pkg::MODE_DEMAND && drq_i[ch_reg] && !mask_reg[ch_reg]);

    // ************************************************************
    // Transfer engine
    // ************************************************************
    // Every cycle in ST_XFER is one byte on the bus; outputs are registered
    always_comb begin
        state_next = state_reg;
        ch_next = ch_reg;
        dack_next = 4'h0;
        maddr_next = maddr_reg;
        mrd_next = 1'b0;
        mwr_next = 1'b0;
        mwd_next = mwd_reg;
        step_ch = 4'h0;
        tc_hit = 4'h0;
        copy_end = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (copy_go) begin
                    state_next = ST_CP_RD;
                    mrd_next = 1'b1;
                    maddr_next = addr_reg[dmc_pkg::CH_SRC];
                end else if (|dev_req) begin
                    state_next = ST_XFER;
                    ch_next = pick;
                    dack_next = 4'h1 << pick;
                    maddr_next = addr_reg[pick];
                    mrd_next = !dir_wr[pick];
                    mwr_next = dir_wr[pick];
                end
            end
            ST_XFER: begin
                step_ch = 4'h1 << ch_reg;
                tc_hit = cur_last ? step_ch : 4'h0;
                if (!cur_last && keep_on) begin
                    dack_next = step_ch;
                    maddr_next = addr_cur + dmc_pkg::WORD_STEP;
                    mrd_next = !dir_wr[ch_reg];
                    mwr_next = dir_wr[ch_reg];
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_CP_RD: begin
                state_next = ST_CP_WAIT;
            end
            ST_CP_WAIT: begin
                state_next = ST_CP_WR;
                mwd_next = mem_rdata_i;
                mwr_next = 1'b1;
                maddr_next = addr_reg[dmc_pkg::CH_DST];
            end
            ST_CP_WR: begin
                step_ch = dmc_pkg::COPY_PAIR;
                // Length and the end mark both belong to channel 1
                if (dst_last) begin
                    tc_hit = dmc_pkg::COPY_TC;
                    copy_end = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    state_next = ST_CP_RD;
                    mrd_next = 1'b1;
                    maddr_next = addr_reg[dmc_pkg::CH_SRC] + dmc_pkg::WORD_STEP;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Flags and interrupts
    // ************************************************************
    // A new end mark in the clearing cycle survives the clear
    wire [3:0] tc_next = (tc_reg & ~{4{rd_stat}}) | tc_hit;
    wire [3:0] ist_next = (ist_reg & ~(wr_ist ? reg_wdata_i[3:0] : 4'h0)) | tc_hit;

    // ************************************************************
    // Read data
    // ************************************************************
    wire [15:0] chan_word = acc_cnt ? cnt_reg[acc_ch] : addr_reg[acc_ch];
    wire [7:0] chan_byte = ptr_reg ? chan_word[15:8] : chan_word[7:0];
    wire [7:0] rd_mux =
        rd_chan ? chan_byte :
        (rd_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_CMD)) ? cmd_reg :
        (rd_dma && dmc_hit(reg_addr_i, dmc_pkg::OFF_MASK)) ? {4'h0, mask_reg} :
        rd_stat ? {drq_i | sreq_reg, tc_reg} :
        dmc_hit(reg_addr_i, dmc_pkg::OFF_WINDOW) ? window_reg :
        dmc_hit(reg_addr_i, dmc_pkg::OFF_IRQ_STAT) ? {4'h0, ist_reg} :
        dmc_hit(reg_addr_i, dmc_pkg::OFF_IRQ_MASK) ? {4'h0, imask_reg} : 8'h00;

    // Software-facing registers
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            window_reg <= dmc_pkg::WINDOW_RST;
            cmd_reg <= dmc_pkg::CMD_RST;
            mask_reg <= dmc_pkg::MASK_RST;
            sreq_reg <= 4'h0;
            tc_reg <= 4'h0;
            ist_reg <= 4'h0;
            imask_reg <= 4'h0;
            ptr_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            if (wr_win) window_reg <= reg_wdata_i;
            if (wr_cmd) cmd_reg <= reg_wdata_i;
            if (wr_imask) imask_reg <= reg_wdata_i[3:0];
            mask_reg <= mask_next;
            sreq_reg <= sreq_next;
            tc_reg <= tc_next;
            ist_reg <= ist_next;
            ptr_reg <= ptr_next;
            rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // Engine and bus-side output flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_IDLE;
            ch_reg <= 2'h0;
            dack_reg <= 4'h0;
            maddr_reg <= dmc_pkg::WORD_RST;
            mrd_reg <= 1'b0;
            mwr_reg <= 1'b0;
            mwd_reg <= 8'h00;
            tco_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ch_reg <= ch_next;
            dack_reg <= dack_next;
            maddr_reg <= maddr_next;
            mrd_reg <= mrd_next;
            mwr_reg <= mwr_next;
            mwd_reg <= mwd_next;
            tco_reg <= |tc_hit;
            irq_reg <= |(ist_next & imask_reg);
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign dack_o = dack_reg;
    assign mem_addr_o = maddr_reg;
    assign mem_rd_o = mrd_reg;
    assign mem_wr_o = mwr_reg;
    assign mem_wdata_o = mwd_reg;
    assign tc_o = tco_reg;
    assign irq_o = irq_reg;
endmodule

`default_nettype wire

// >>> rtl/dmc_pkg.sv
// Constants for the four-channel byte DMA engine with memory copy.
// Assumes an 8-bit register port with a 5-bit address and a 16-bit memory address.
package dmc_pkg;
    // ************************************************************
    // Register port offsets
    // ************************************************************
    localparam int REG_AW = 5;
    localparam logic [4:0] OFF_CHAN_BASE = 5'h00; // addr/count pairs, two per channel
    localparam logic [4:0] OFF_CMD = 5'h08;
    localparam logic [4:0] OFF_REQ = 5'h09;
    localparam logic [4:0] OFF_MASK = 5'h0a;
    localparam logic [4:0] OFF_MODE = 5'h0b;
    localparam logic [4:0] OFF_CLR_PTR = 5'h0c;
    localparam logic [4:0] OFF_STATUS = 5'h0d;
    localparam logic [4:0] OFF_WINDOW = 5'h10;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h11;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h12;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CMD_COPY_BIT = 0; // memory_copy_enable_bit
    localparam int SEL_CH_LSB = 0; // channel select in req/mask/mode writes
    localparam int SEL_SET_BIT = 2; // set (1) or clear (0) in req/mask writes
    localparam int MODE_DIR_BIT = 3; // 1: peripheral to memory (memory write)
    localparam int MODE_SEL_LSB = 6;
    localparam int ADDR_HI_BIT = 15; // 0: low 32 KB, ISA-side memory

    // Transfer modes held in mode bits 7:6
    localparam logic [1:0] MODE_DEMAND = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_BLOCK = 2'h2;

    // ************************************************************
    // Reset values and constants
    // ************************************************************
    localparam logic [7:0] WINDOW_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] MASK_RST = 4'hf; // all channels masked out of reset
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0001;
    localparam logic [15:0] CNT_LAST = 16'h0000; // count of the final byte
    localparam logic [3:0] COPY_PAIR = 4'h3; // channels 0 and 1
    localparam logic [3:0] COPY_TC = 4'h2; // channel 1 ends a copy
    localparam logic [1:0] CH_SRC = 2'h0;
    localparam logic [1:0] CH_DST = 2'h1;
endpackage

// >>> tb/dmc_channel_copy_chk.sv
// Concurrent checks on the DMA engine ports.
// Assumes one clock and an active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module dmc_channel_copy_chk (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [3:0] drq_i,
    input wire logic [3:0] dack_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic tc_o,
    input wire logic irq_o
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_rdata_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_dack_hot; $onehot0(dack_o); endproperty
    a_dack_hot: assert property (p_dack_hot) else $error("dack not one-hot");
    // Low channels must never serve the ISA half
    property p_low_ch; dack_o[1:0] != 2'h0 |-> mem_addr_o[15]; endproperty
    a_low_ch: assert property (p_low_ch) else $error("ch0/1 on ISA memory");
    property p_one_strobe; dack_o != 4'h0 |-> (mem_rd_o ^ mem_wr_o); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("device byte strobes");
    property p_tc_pulse; tc_o |=> !tc_o; endproperty
    a_tc_pulse: assert property (p_tc_pulse) else $error("tc longer than one");
    // Copy byte: read, wait, write the captured data
    property p_copy_wr;
        mem_rd_o && dack_o == 4'h0 |-> ##2 (mem_wr_o && mem_wdata_o == $past(mem_rdata_i));
    endproperty
    a_copy_wr: assert property (p_copy_wr) else $error("copy write missing");
    property p_tc_cause; tc_o |-> $past(mem_rd_o || mem_wr_o); endproperty
    a_tc_cause: assert property (p_tc_cause) else $error("tc without byte");
    property p_addr_step;
        dack_o != 4'h0 && dack_o == $past(dack_o) |-> mem_addr_o == $past(mem_addr_o) + 16'h0001;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address not stepped");
endmodule
bind dmc_channel_copy dmc_channel_copy_chk u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .drq_i(drq_i), .dack_o(dack_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .tc_o(tc_o), .irq_o(irq_o));
`default_nettype wire

// >>> tb/dmc_isa_mem.sv
// ISA-side RAM model for the DMA engine.
// Assumes read data is wanted in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module dmc_isa_mem (
    input wire logic ref_clk_i, // Clock
    input wire logic [15:0] mem_addr_i, // Byte address
    input wire logic mem_rd_i, // Read strobe
    input wire logic mem_wr_i, // Write strobe
    input wire logic [7:0] mem_wdata_i, // Write data
    output logic [7:0] mem_rdata_o // Read data
);
    logic [7:0] mem [0:65535];
    initial mem_rdata_o = 8'h00;
    // Outside an answer the bus flips, so stale data never matches
    always @(posedge ref_clk_i) begin
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        mem_rdata_o <= mem_rd_i ? mem[mem_addr_i] : ~mem_rdata_o;
    end
endmodule
`default_nettype wire

// >>> tb/test_dmc_channel_copy.sv
// Self-checking bench for the DMA engine with memory copy.
// Assumes the checker is bound and the RAM model sits on the memory port.
`timescale 1ns/1ps
`default_nettype none
module test_dmc_channel_copy;
    localparam logic [7:0] WSEL = 8'h40;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] drq = 4'h0;
    logic [7:0] rdata, mwdata, mrdata;
    logic [3:0] dack;
    logic [15:0] maddr;
    logic mrd, mwr, tc, irq;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    dmc_channel_copy #(.WINDOW_SEL(WSEL)) DUT (.ref_clk_i(clk), .arst_n_i(rst_n),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .drq_i(drq), .dack_o(dack), .mem_addr_o(maddr),
        .mem_rd_o(mrd), .mem_wr_o(mwr), .mem_wdata_o(mwdata), .mem_rdata_i(mrdata),
        .tc_o(tc), .irq_o(irq));
    dmc_isa_mem MEM (.ref_clk_i(clk), .mem_addr_i(maddr), .mem_rd_i(mrd),
        .mem_wr_i(mwr), .mem_wdata_i(mwdata), .mem_rdata_o(mrdata));
    // ************************************************************
    // Clock, timeout and helpers
    // ************************************************************
    initial forever #12.5 clk = ~clk;
    // Whole run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // Program one channel, raise its request, count the bytes served
    task automatic dev_xfer(input logic [1:0] ch, input logic [7:0] mode,
        input logic [15:0] a, input logic [7:0] cnt, input int exp_n);
        int n;
        int t;
        n = 0;
        t = 0;
        wreg(dmc_pkg::OFF_CLR_PTR, 8'h00);
        wreg({2'h0, ch, 1'b0}, a[7:0]);
        wreg({2'h0, ch, 1'b0}, a[15:8]);
        wreg({2'h0, ch, 1'b1}, cnt);
        wreg({2'h0, ch, 1'b1}, 8'h00);
        wreg(dmc_pkg::OFF_MODE, mode);
        wreg(dmc_pkg::OFF_MASK, {6'h00, ch});
        drq[ch] <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (dack !== 4'h0) begin
                chk({12'h000, dack}, 16'h0001 << ch);
                chk(maddr, a + 16'(n));
                chk({14'h0, mrd, mwr}, {14'h0, ~mode[3], mode[3]});
                n++;
            end
            if (tc === 1'b1) t++;
        end
        chk(16'(n), 16'(exp_n));
        chk(16'(t), 16'(exp_n != 0));
        drq <= 4'h0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_window();
        rchk(dmc_pkg::OFF_IRQ_MASK, 8'h00);
        rchk(dmc_pkg::OFF_MASK, 8'h00);
        wreg(5'h04, 8'h55);
        wreg(dmc_pkg::OFF_WINDOW, WSEL);
        rchk(dmc_pkg::OFF_MASK, 8'h0f);
        rchk(5'h1f, 8'h00);
        wreg(dmc_pkg::OFF_CLR_PTR, 8'h00);
        rchk(5'h04, 8'h00);
        wreg(5'h04, 8'h34);
        wreg(5'h04, 8'h12);
        wreg(dmc_pkg::OFF_CLR_PTR, 8'h00);
        rchk(5'h04, 8'h12);
        rchk(5'h04, 8'h34);
    endtask
    task automatic t_device();
        wreg(dmc_pkg::OFF_IRQ_MASK, 8'h04);
        dev_xfer(2'h2, 8'h8a, 16'h0100, 8'h02, 3);
        chk({15'h0, irq}, 16'h0001);
        rchk(dmc_pkg::OFF_STATUS, 8'h04);
        rchk(dmc_pkg::OFF_STATUS, 8'h00);
        wreg(dmc_pkg::OFF_IRQ_STAT, 8'h04);
        repeat (2) @(posedge clk);
        #1 chk({15'h0, irq}, 16'h0000);
        dev_xfer(2'h3, 8'h03, 16'h8000, 8'h00, 1);
        repeat (2) @(posedge clk);
        #1 chk({15'h0, irq}, 16'h0000);
        rchk(dmc_pkg::OFF_IRQ_STAT, 8'h08);
        dev_xfer(2'h3, 8'h43, 16'h0200, 8'h01, 2);
        dev_xfer(2'h0, 8'h40, 16'h0010, 8'h00, 0);
        dev_xfer(2'h0, 8'h48, 16'h8020, 8'h00, 1);
        wreg(dmc_pkg::OFF_MASK, 8'h04);
    endtask
    task automatic t_copy();
        int nw;
        int nt;
        nw = 0;
        nt = 0;
        MEM.mem[16'h0020] = 8'ha5;
        MEM.mem[16'h0021] = 8'h3c;
        MEM.mem[16'h0042] = 8'h77;
        wreg(dmc_pkg::OFF_MASK, 8'h05);
        wreg(dmc_pkg::OFF_CLR_PTR, 8'h00);
        wreg(5'h00, 8'h20);
        wreg(5'h00, 8'h00);
        wreg(5'h01, 8'h05);
        wreg(5'h01, 8'h00);
        wreg(5'h02, 8'h40);
        wreg(5'h02, 8'h00);
        wreg(5'h03, 8'h01);
        wreg(5'h03, 8'h00);
        wreg(dmc_pkg::OFF_MODE, 8'h80);
        wreg(dmc_pkg::OFF_MODE, 8'h81);
        wreg(dmc_pkg::OFF_CMD, 8'h01);
        repeat (10) begin
            @(posedge clk);
            #1 chk({14'h0, mrd, mwr}, 16'h0000);
        end
        rchk(dmc_pkg::OFF_STATUS, 8'h09);
        wreg(dmc_pkg::OFF_REQ, 8'h04);
        repeat (40) begin
            @(posedge clk);
            #1;
            if (mwr === 1'b1) nw++;
            if (tc === 1'b1) nt++;
        end
        chk(16'(nw), 16'd2);
        chk(16'(nt), 16'd1);
        chk({MEM.mem[16'h0041], MEM.mem[16'h0040]}, 16'h3ca5);
        chk({8'h00, MEM.mem[16'h0042]}, 16'h0077);
        chk({15'h0, irq}, 16'h0000);
        rchk(dmc_pkg::OFF_STATUS, 8'h02);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_window();
        t_device();
        t_copy();
        tally_and_finish();
    end
endmodule
`default_nettype wire
